//--- emt_top.sv
// eight-bit modulo timer with its AHB-Lite register slave
module emt_top
   import emt_pkg::*;
(
   // clock and reset
   input  wire logic        MCLK_I,
   input  wire logic        RSTN_I,
   // AHB-Lite slave
   input  wire logic        HSEL_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic        HREADY_I,
   input  wire logic [31:0] HWDATA_I,
   output logic      [31:0] HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   // count sources
   input  wire logic        FIXED_RATE_CLOCK_I,
   input  wire logic        EXT_COUNT_PIN_I,
   // overflow interrupt request
   output logic             IRQ_O
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        counter_halt;
      logic        overflow_irq_enable;
      logic        overflow_flag;
      logic        armed;
      emt_source_e source_select;
      logic [3:0]  divider_select;
      logic [7:0]  wrap;
      logic [7:0]  count;
      logic        ph_valid;
      logic        ph_write;
      logic        ph_mapped;
      logic [1:0]  ph_idx;
      logic [31:0] rdata;
      logic        ready;
      logic        resp;
      logic        irq;
   } emt_state_s;

   // stopped, zeroed, bus clock, divide by one
   localparam emt_state_s STATE_RESET = '{
      counter_halt:        RST_HALT,
      overflow_irq_enable: 1'b0,
      overflow_flag:       1'b0,
      armed:               1'b0,
      source_select:       SRC_BUS_CLOCK,
      divider_select:      RST_DIVIDER,
      wrap:                RST_WRAP,
      count:               RST_COUNT,
      ph_valid:            1'b0,
      ph_write:            1'b0,
      ph_mapped:           1'b0,
      ph_idx:              IDX_CONTROL_STATUS,
      rdata:               32'h0000_0000,
      ready:               1'b1,
      resp:                1'b0,
      irq:                 1'b0
   };

   emt_state_s  s;
   emt_state_s  next_s;

   // ----------------------------------------------------------------
   // count sources and prescaler
   // ----------------------------------------------------------------
   emt_presc_if presc_link ();

   logic        fixed_rise;
   logic        pin_rise;
   logic        pin_fall;

   emt_edge u_fixed_edge
   (
      .clk_i  (MCLK_I),
      .rstn_i (RSTN_I),
      .pin_i  (FIXED_RATE_CLOCK_I),
      .rise_o (fixed_rise),
      .fall_o ()
   );

   emt_edge u_pin_edge
   (
      .clk_i  (MCLK_I),
      .rstn_i (RSTN_I),
      .pin_i  (EXT_COUNT_PIN_I),
      .rise_o (pin_rise),
      .fall_o (pin_fall)
   );

   emt_presc u_presc
   (
      .clk_i  (MCLK_I),
      .rstn_i (RSTN_I),
      .p      (presc_link.presc)
   );

   always_comb
   begin
      unique case (s.source_select)
         SRC_BUS_CLOCK:  presc_link.src_tick = 1'b1;
         SRC_FIXED_RATE: presc_link.src_tick = fixed_rise;
         SRC_PIN_FALL:   presc_link.src_tick = pin_fall;
         SRC_PIN_RISE:   presc_link.src_tick = pin_rise;
      endcase
   end

   assign presc_link.div_sel = s.divider_select;
   assign presc_link.clear   = s.counter_halt;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic        take;
   logic        addr_mapped;
   logic [1:0]  addr_idx;
   logic        data_wr;
   logic        wr_control;
   logic        wr_clock;
   logic        wr_wrap;
   logic        rd_control;

   always_comb
   begin
      take        = HSEL_I & HREADY_I & ((HTRANS_I & HTRANS_NONSEQ_BIT) != 2'h0);
      addr_mapped = (HADDR_I[BLOCK_MSB:BLOCK_LSB] == '0);
      addr_idx    = HADDR_I[IDX_MSB:IDX_LSB];
      data_wr     = s.ph_valid & s.ph_write & s.ph_mapped;
      wr_control  = data_wr & (s.ph_idx == IDX_CONTROL_STATUS);
      wr_clock    = data_wr & (s.ph_idx == IDX_CLOCK_SETUP);
      // count index has no write strobe
      wr_wrap     = data_wr & (s.ph_idx == IDX_WRAP_VALUE);
      rd_control  = take & ~HWRITE_I & addr_mapped & (addr_idx == IDX_CONTROL_STATUS);
   end

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   logic        step;
   logic        overflow;
   logic        restart;
   logic [7:0]  top_value;

   always_comb
   begin
      // zero wrap runs the full range
      top_value = (s.wrap == 8'h00) ? COUNT_FULL : s.wrap;
      step      = presc_link.pre_tick & ~s.counter_halt;
      overflow  = step & (s.count == top_value);
      restart   = wr_control & HWDATA_I[POS_RESTART];
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic        flag_clear;

   always_comb
   begin
      next_s       = s;
      next_s.ready = 1'b1;
      next_s.resp  = 1'b0;

      // control, clock and wrap writes
      if (wr_control)
      begin
         next_s.counter_halt        = HWDATA_I[POS_COUNTER_HALT];
         next_s.overflow_irq_enable = HWDATA_I[POS_IRQ_ENABLE];
      end
      if (wr_clock)
      begin
         next_s.source_select  = emt_source_e'(HWDATA_I[POS_SOURCE_MSB:POS_SOURCE_LSB]);
         next_s.divider_select = HWDATA_I[POS_DIVIDER_MSB:POS_DIVIDER_LSB];
      end
      if (wr_wrap)
         next_s.wrap = HWDATA_I[7:0];

      if (overflow)
         next_s.count = 8'h00;
      else if (step)
         next_s.count = s.count + 8'h01;

      if (restart || (wr_wrap && !s.counter_halt))
         next_s.count = 8'h00;

      // armed clear, restart and wrap clears
      flag_clear = (wr_control & s.armed & ~HWDATA_I[POS_OVERFLOW_FLAG]) | restart | wr_wrap;
      if (flag_clear)
         next_s.overflow_flag = 1'b0;
      if (overflow)
         next_s.overflow_flag = 1'b1;

      // arm on a read that sees the flag
      if (rd_control && s.overflow_flag)
         next_s.armed = 1'b1;
      if (wr_control || overflow)
         next_s.armed = 1'b0;

      // address phase capture
      next_s.ph_valid  = take;
      next_s.ph_write  = HWRITE_I;
      next_s.ph_mapped = addr_mapped;
      next_s.ph_idx    = addr_idx;

      // read data reflects this edge's updates
      next_s.rdata = 32'h0000_0000;
      if (take && !HWRITE_I && addr_mapped)
      begin
         unique case (addr_idx)
            IDX_CONTROL_STATUS:
            begin
               next_s.rdata[POS_OVERFLOW_FLAG] = next_s.overflow_flag;
               next_s.rdata[POS_IRQ_ENABLE]    = next_s.overflow_irq_enable;
               next_s.rdata[POS_COUNTER_HALT]  = next_s.counter_halt;
            end
            IDX_CLOCK_SETUP:
            begin
               next_s.rdata[POS_SOURCE_MSB:POS_SOURCE_LSB]   = next_s.source_select;
               next_s.rdata[POS_DIVIDER_MSB:POS_DIVIDER_LSB] = next_s.divider_select;
            end
            IDX_COUNT_VALUE:
               next_s.rdata[7:0] = next_s.count;
            IDX_WRAP_VALUE:
               next_s.rdata[7:0] = next_s.wrap;
         endcase
      end

      next_s.irq = next_s.overflow_flag & next_s.overflow_irq_enable;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge MCLK_I)
   begin
      if (!RSTN_I)
         s <= STATE_RESET;
      else
         s <= next_s;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign HRDATA_O    = s.rdata;
   assign HREADYOUT_O = s.ready;
   assign HRESP_O     = s.resp;
   assign IRQ_O       = s.irq;

endmodule

//--- emt_pkg.sv
// constants and types shared by the eight-bit modulo timer
//
// Notes on behaviour
// - three modes: stopped, free-running, modulo; stopped after reset.
// - running with nonzero wrap is modulo; zero wrap wraps through full range.
// - reset: halted, count zero, wrap zero, bus clock source, divide by one.
// - counting while halt bit is zero, count held while it is one.
// - four sources: bus clock, fixed-rate clock, pin falling or rising edge.
// - new source while running keeps the count and continues with it.
// - prescaler divides by nine power-of-two ratios, 1 through 256.
// - new divider while running keeps the count and continues at new rate.
// - wrap accepts 0x01 to 0xff for modulo; reset value zero runs free.
// - count increments until equal to wrap, next increment returns to zero.
// - overflow flag sets exactly on the wrap-to-zero transition.
// - wrap write while running forces count zero and clears overflow flag.
// - a zero write clears the flag only after a read seeing it set.
// - overflow between arming read and clearing write cancels the clear.
// - writing one to restart bit or any wrap write clears the flag.
// - interrupt request whenever flag and interrupt enable are both one.
// - source codes: 00 bus, 01 fixed-rate, 10 pin falling, 11 pin rising.
// - divider codes 0000 to 1000 give 1 to 256; above 1000 gives 256.
// - count register is read-only; writes leave the count unchanged.
package emt_pkg;

   // ----------------------------------------------------------------
   // register indices (byte address is index times four)
   // ----------------------------------------------------------------
   localparam logic [1:0]  IDX_CONTROL_STATUS = 2'h0;
   localparam logic [1:0]  IDX_CLOCK_SETUP    = 2'h1;
   localparam logic [1:0]  IDX_COUNT_VALUE    = 2'h2;
   localparam logic [1:0]  IDX_WRAP_VALUE     = 2'h3;
   localparam int          IDX_LSB            = 2;
   localparam int          IDX_MSB            = 3;
   localparam int          BLOCK_MSB          = 31;
   localparam int          BLOCK_LSB          = 4;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int          POS_OVERFLOW_FLAG  = 7;
   localparam int          POS_IRQ_ENABLE     = 6;
   localparam int          POS_RESTART        = 5;
   localparam int          POS_COUNTER_HALT   = 4;
   localparam int          POS_SOURCE_LSB     = 4;
   localparam int          POS_SOURCE_MSB     = 5;
   localparam int          POS_DIVIDER_LSB    = 0;
   localparam int          POS_DIVIDER_MSB    = 3;

   // ----------------------------------------------------------------
   // encodings and reset values
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_BUS_CLOCK  = 2'h0,
      SRC_FIXED_RATE = 2'h1,
      SRC_PIN_FALL   = 2'h2,
      SRC_PIN_RISE   = 2'h3
   } emt_source_e;

   localparam logic [3:0]  DIVIDER_MAX        = 4'h8;
   localparam logic [3:0]  RST_DIVIDER        = 4'h0;
   localparam logic [7:0]  RST_WRAP           = 8'h00;
   localparam logic [7:0]  RST_COUNT          = 8'h00;
   localparam logic [7:0]  COUNT_FULL         = 8'hff;
   localparam logic        RST_HALT           = 1'b1;
   localparam logic [1:0]  HTRANS_NONSEQ_BIT  = 2'h2;

endpackage

//--- emt_presc_if.sv
// link between the timer core and its prescaler
interface emt_presc_if;
   logic        src_tick;
   logic [3:0]  div_sel;
   logic        clear;
   logic        pre_tick;

   modport core
   (
      output src_tick,
      output div_sel,
      output clear,
      input  pre_tick
   );

   modport presc
   (
      input  src_tick,
      input  div_sel,
      input  clear,
      output pre_tick
   );
endinterface

//--- emt_edge.sv
// three-stage synchroniser with filtered edge pulses
module emt_edge
   import emt_pkg::*;
(
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rstn_i,
   // asynchronous input
   input  wire logic pin_i,
   // single-cycle edge enables
   output logic      rise_o,
   output logic      fall_o
);

   typedef struct packed {
      logic       s1;
      logic       s2;
      logic       s3;
      logic       primed;
      logic       level;
      logic       rise;
      logic       fall;
      logic [1:0] fill;
   } emt_edge_s;

   // pin has reached the third stage
   localparam logic [1:0] FILL_DONE = 2'h3;

   emt_edge_s s;
   emt_edge_s next_s;

   always_comb
   begin
      next_s      = s;
      next_s.s1   = pin_i;
      next_s.s2   = s.s1;
      next_s.s3   = s.s2;
      next_s.rise = 1'b0;
      next_s.fall = 1'b0;
      // reset zeros are not the pin level, wait for the real one
      if (s.fill != FILL_DONE)
         next_s.fill = s.fill + 2'h1;
      else if (s.s2 == s.s3)
      begin
         // first agreement after reset only loads the level
         next_s.primed = 1'b1;
         next_s.level  = s.s3;
         if (s.primed && (s.s3 != s.level))
         begin
            next_s.rise = s.s3;
            next_s.fall = ~s.s3;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
         s <= '0;
      else
         s <= next_s;
   end

   assign rise_o = s.rise;
   assign fall_o = s.fall;

endmodule

//--- emt_presc.sv
// power-of-two prescaler of the selected count source
module emt_presc
   import emt_pkg::*;
(
   // clock and reset
   input  wire logic  clk_i,
   input  wire logic  rstn_i,
   // core link
   emt_presc_if.presc p
);

   typedef struct packed {
      logic [7:0] cnt;
   } emt_presc_s;

   emt_presc_s s;
   emt_presc_s next_s;
   logic [3:0] div_eff;
   logic [8:0] span;
   logic [7:0] mask;

   always_comb
   begin
      div_eff = (p.div_sel > DIVIDER_MAX) ? DIVIDER_MAX : p.div_sel;
      span    = (9'h001 << div_eff) - 9'h001;
      mask    = span[7:0];
      next_s  = s;
      if (p.clear)
         next_s.cnt = 8'h00;
      else if (p.src_tick)
         next_s.cnt = s.cnt + 8'h01;
      p.pre_tick = p.src_tick & ~p.clear & ((s.cnt & mask) == mask);
   end

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
         s <= '0;
      else
         s <= next_s;
   end

endmodule

//--- emt_monitor.sv
// port checker of the eight-bit modulo timer
module emt_monitor
   import emt_pkg::*;
(
   // clock and reset
   input wire logic        MCLK_I,
   input wire logic        RSTN_I,
   // bus
   input wire logic        HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0]  HTRANS_I,
   input wire logic        HWRITE_I,
   input wire logic        HREADY_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic [31:0] HRDATA_O,
   input wire logic        HREADYOUT_O,
   input wire logic        HRESP_O,
   // interrupt
   input wire logic        IRQ_O
);
   logic take;
   logic wr_ph;
   logic rd_ph;
   logic cs_ph;
   logic en_q;

   assign take = HSEL_I && HREADY_I && HTRANS_I[1];

   // ------------------------------
   // data phase and enable shadow
   // ------------------------------
   always_ff @(posedge MCLK_I)
   begin
      if (!RSTN_I)
      begin
         wr_ph <= 1'b0;
         rd_ph <= 1'b0;
         cs_ph <= 1'b0;
         en_q  <= 1'b0;
      end
      else
      begin
         wr_ph <= take && HWRITE_I;
         rd_ph <= take && !HWRITE_I;
         cs_ph <= take && HADDR_I == 32'h0;
         if (wr_ph && cs_ph)
         begin
            en_q <= HWDATA_I[POS_IRQ_ENABLE];
         end
      end
   end

   // ------------------------------
   // properties
   // ------------------------------
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!RSTN_I);

   sequence rd_taken;
      take && !HWRITE_I;
   endsequence
   sequence cs_read;
      rd_taken ##0 HADDR_I == 32'h0;
   endsequence
   sequence off_map_read;
      rd_taken ##0 HADDR_I[BLOCK_MSB:BLOCK_LSB] != 28'h0;
   endsequence

   rst_irq_low_a: assert property ($rose(RSTN_I) |-> !IRQ_O)
      else $error("irq high after reset");
   ready_high_a: assert property (HREADYOUT_O)
      else $error("wait state inserted");
   resp_okay_a: assert property (!HRESP_O)
      else $error("error response");
   idle_rdata_zero_a: assert property (!rd_ph |-> HRDATA_O == 32'h0)
      else $error("read data outside data phase");
   unmapped_read_zero_a: assert property (off_map_read |=> HRDATA_O == 32'h0)
      else $error("unmapped read not zero");
   cs_read_bits_a: assert property (cs_read |=> HRDATA_O[31:8] == 24'h0 && !HRDATA_O[POS_RESTART])
      else $error("control read shows restart or upper bits");
   irq_needs_en_a: assert property (IRQ_O |-> en_q)
      else $error("irq without enable");
   irq_fall_write_a: assert property ($fell(IRQ_O) |-> $past(wr_ph))
      else $error("irq dropped without a write");
endmodule

bind emt_top emt_monitor u_mon (.MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
   .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HWDATA_I(HWDATA_I), .HRDATA_O(HRDATA_O),
   .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .IRQ_O(IRQ_O));

//--- emt_tb.sv
// self-checking bench of the eight-bit modulo timer
module emt_tb
   import emt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk    = 1'b0;
   logic        rstn   = 1'b0;
   logic        hsel   = 1'b0;
   logic [31:0] haddr  = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        frc    = 1'b0;
   logic        pin    = 1'b0;
   wire logic   hready;
   logic [31:0] hrdata;
   logic        hresp;
   logic        irq;
   logic [31:0] rv;
   logic [7:0]  c;
   int          mismatches = 0;
   int          n_checks   = 0;

   localparam logic [31:0] A_CS = {28'h0, IDX_CONTROL_STATUS, 2'h0};
   localparam logic [31:0] A_CK = {28'h0, IDX_CLOCK_SETUP, 2'h0};
   localparam logic [31:0] A_CN = {28'h0, IDX_COUNT_VALUE, 2'h0};
   localparam logic [31:0] A_WR = {28'h0, IDX_WRAP_VALUE, 2'h0};

   always #12.5 clk = ~clk;

   emt_top u_dut (.MCLK_I(clk), .RSTN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
      .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HREADY_I(hready), .HWDATA_I(hwdata), .HRDATA_O(hrdata),
      .HREADYOUT_O(hready), .HRESP_O(hresp), .FIXED_RATE_CLOCK_I(frc), .EXT_COUNT_PIN_I(pin), .IRQ_O(irq));

   // ------------------------------
   // bus and helper tasks
   // ------------------------------
   task end_of_test;
      if (mismatches == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask

   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rv = hrdata;
   endtask

   task wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task rc(input string n, input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, rv, e);
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // toggles the fixed-rate input or the count pin, slow enough for the synchroniser
   task tog(input bit f, input int n);
      repeat (n)
      begin
         cyc(8);
         if (f)
            frc <= ~frc;
         else
            pin <= ~pin;
      end
      cyc(8);
   endtask

   // ------------------------------
   // scenarios
   // ------------------------------
   task t_reset;
      rc("cs rst", A_CS, 32'h10);
      rc("clk rst", A_CK, 32'h0);
      rc("wrap rst", A_WR, 32'h0);
      cyc(30);
      rc("cnt stopped", A_CN, 32'h0);
      wr(A_CN, 32'h55);
      rc("cnt ro", A_CN, 32'h0);
      rc("unmapped", 32'h10, 32'h0);
      for (int s = 0; s < 4; s++)
      begin
         wr(A_CK, {26'h0, 2'(s), 4'h3});
         rc("src sel", A_CK, {26'h0, 2'(s), 4'h3});
      end
      wr(A_WR, 32'hff);
      rc("wrap max", A_WR, 32'hff);
   endtask

   task t_free;
      wr(A_WR, 32'h0);
      wr(A_CK, 32'h0);
      wr(A_CS, 32'h20);
      cyc(200);
      rc("no ovf", A_CS, 32'h0);
      cyc(100);
      wr(A_CS, 32'h10);
      rc("ovf free", A_CS, 32'h90);
      wr(A_CS, 32'h10);
      rc("flag clr", A_CS, 32'h10);
   endtask

   task t_mod;
      wr(A_WR, 32'hc8);
      wr(A_CS, 32'h20);
      cyc(240);
      bus(1'b0, A_CN, 32'h0);
      chk("cnt le wrap", {31'h0, rv <= 32'hc8}, 32'h1);
      rc("ovf mod", A_CS, 32'h80);
      wr(A_WR, 32'hc8);
      rc("wrap wr flag", A_CS, 32'h0);
      bus(1'b0, A_CN, 32'h0);
      chk("wrap wr cnt", {31'h0, rv < 32'h8}, 32'h1);
   endtask

   task t_irq;
      wr(A_CS, 32'h10);
      wr(A_WR, 32'h07);
      wr(A_CS, 32'h60);
      // overflow every eight cycles, arming read lands just before the second
      cyc(13);
      rc("irq flag", A_CS, 32'hc0);
      chk("irq on", {31'h0, irq}, 32'h1);
      wr(A_CS, 32'h0);
      rc("clr cancel", A_CS, 32'h80);
      chk("irq mask", {31'h0, irq}, 32'h0);
      wr(A_CS, 32'h30);
      rc("restart cs", A_CS, 32'h10);
      rc("restart cnt", A_CN, 32'h0);
   endtask

   task t_src;
      wr(A_WR, 32'h0);
      wr(A_CK, 32'h0);
      wr(A_CS, 32'h20);
      wr(A_CK, 32'h30);
      bus(1'b0, A_CN, 32'h0);
      c = rv[7:0];
      rc("src keep", A_CN, {24'h0, c});
      chk("src nz", {31'h0, c != 8'h0}, 32'h1);
      tog(1'b0, 6);
      rc("pin rise", A_CN, {24'h0, c + 8'h3});
      wr(A_CK, 32'h21);
      tog(1'b0, 8);
      rc("pin fall", A_CN, {24'h0, c + 8'h5});
      wr(A_CK, 32'h10);
      tog(1'b1, 6);
      rc("fixed", A_CN, {24'h0, c + 8'h8});
   endtask

   task t_div;
      wr(A_CS, 32'h30);
      wr(A_CK, 32'h0f);
      rc("div rb", A_CK, 32'h0f);
      wr(A_CS, 32'h0);
      cyc(200);
      rc("div slow a", A_CN, 32'h0);
      cyc(100);
      rc("div slow b", A_CN, 32'h1);
   endtask

   initial
   begin
      cyc(20);
      rstn <= 1'b1;
      t_reset;
      t_free;
      t_mod;
      t_irq;
      t_src;
      t_div;
      end_of_test;
   end

   // watchdog, about five times the expected run
   initial
   begin
      #150000;
      mismatches++;
      end_of_test;
   end
endmodule
